// >>> rtl/tc8_pkg.sv
// constants, offsets and field layout for the 8-bit timer/counter
package tc8_pkg;

   // system clock
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS = 50;

   // address spaces: i/o offsets, and the same registers shifted in data space
   localparam logic [6:0] IO_SPACE_MAX    = 7'h3f;
   localparam logic [6:0] DATA_SPACE_BIAS = 7'h20;

   // register i/o offsets
   localparam logic [6:0] OFF_COUNT_VALUE           = 7'h32;
   localparam logic [6:0] OFF_TIMER_CONTROL         = 7'h33;
   localparam logic [6:0] OFF_TIMER_INTERRUPT_FLAGS = 7'h38;
   localparam logic [6:0] OFF_TIMER_INTERRUPT_MASK  = 7'h39;

   // values after reset
   localparam logic [7:0] RST_COUNT_VALUE   = 8'h00;
   localparam logic [2:0] RST_CLOCK_SELECT  = 3'h0;
   localparam logic       RST_OVERFLOW_FLAG = 1'b0;
   localparam logic       RST_OVF_IRQ_EN    = 1'b0;
   localparam logic [7:0] RST_READ_DATA     = 8'h00;

   // field positions
   localparam int unsigned CS_LSB       = 0;
   localparam int unsigned CS_WIDTH     = 3;
   localparam int unsigned OVF_FLAG_BIT = 0;
   localparam int unsigned OVF_IE_BIT   = 0;

   // counter limits
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_ONE = 8'h01;

   // clock-select codes
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // free-running prescaler and its taps
   localparam int unsigned PRESCALE_WIDTH = 10;
   localparam int unsigned TAP_COUNT      = 4;
   localparam int unsigned TAP_8          = 0;
   localparam int unsigned TAP_64         = 1;
   localparam int unsigned TAP_256        = 2;
   localparam int unsigned TAP_1024       = 3;
   localparam logic [9:0]  TAP_MASK_8     = 10'h007;
   localparam logic [9:0]  TAP_MASK_64    = 10'h03f;
   localparam logic [9:0]  TAP_MASK_256   = 10'h0ff;
   localparam logic [9:0]  TAP_MASK_1024  = 10'h3ff;
   localparam logic [9:0]  PRESCALE_RST   = 10'h000;
   localparam logic [9:0]  PRESCALE_STEP  = 10'h001;

endpackage

// >>> rtl/tc8_prescaler.sv
// free-running prescaler giving one-cycle tap enables
`timescale 1ns/1ps
module tc8_prescaler
(
   input  wire logic                               i_clock,
   input  wire logic                               i_rst_b,
   output logic [tc8_pkg::TAP_COUNT-1:0]           o_tap_en
);

   logic [tc8_pkg::PRESCALE_WIDTH-1:0] div_q;
   logic [tc8_pkg::PRESCALE_WIDTH-1:0] div_d;

   // never stopped or cleared by clock select, so phase is unknown to software
   always_comb
   begin
      div_d = div_q + tc8_pkg::PRESCALE_STEP;
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         div_q <= tc8_pkg::PRESCALE_RST;
      else
         div_q <= div_d;
   end

   // a tap pulses on the last cycle of each divided period
   always_comb
   begin
      o_tap_en[tc8_pkg::TAP_8]    = (div_q & tc8_pkg::TAP_MASK_8) == tc8_pkg::TAP_MASK_8;
      o_tap_en[tc8_pkg::TAP_64]   = (div_q & tc8_pkg::TAP_MASK_64) == tc8_pkg::TAP_MASK_64;
      o_tap_en[tc8_pkg::TAP_256]  = (div_q & tc8_pkg::TAP_MASK_256) == tc8_pkg::TAP_MASK_256;
      o_tap_en[tc8_pkg::TAP_1024] = (div_q & tc8_pkg::TAP_MASK_1024) == tc8_pkg::TAP_MASK_1024;
   end

endmodule

// >>> rtl/tc8_edge_det.sv
// pin sampler and edge detector for the external count pin
`timescale 1ns/1ps
module tc8_edge_det
(
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   input  wire logic i_pin,
   output logic      o_rise,
   output logic      o_fall
);

   logic samp_q;
   logic sync_q;
   logic prev_q;

   // samp_q is read only by sync_q; edges are judged on sync_q and prev_q
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         samp_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         samp_q <= i_pin;
         sync_q <= samp_q;
         prev_q <= sync_q;
      end
   end

   // one pulse per edge; the pin must hold each level over a clock to be seen
   always_comb
   begin
      o_rise = sync_q & ~prev_q;
      o_fall = ~sync_q & prev_q;
   end

endmodule

// >>> rtl/tc8_timer.sv
// 8-bit timer/counter with clock select, overflow flag and overflow interrupt
//
// Function
// - count up by one per timer tick
// - select code zero stops the counter
// - codes one to five: direct, /8../1024
// - codes six, seven: falling, rising pin edges
// - pin edges count even when pin drives
// - cpu reads, writes count at any time
// - cpu write beats count in same cycle
// - maximum wraps to zero on next tick
// - overflow flag sets in the wrap cycle
// - counting only ever sets the flag
// - interrupt service clears the flag
// - irq needs mask bit, global enable, flag
// - count register full width, resets zero
// - timer tick is enable, one clock
// - registers at offset and offset plus 0x20
// - writing one clears flag, zero ignored
// - pin sampled per clock, one tick per edge
// - prescaler runs free of clock select
//
// bus timing: a strobe is taken at the rising edge where it stands high;
// a write lands at that edge, while read data and rvalid follow one clock
// later; rvalid lasts one clock, read data holds until the next read
// pin timing: each pin level must last over one clock or edges are lost;
// an edge reaches the count at the third rising edge after it
// limits: there is no prescaler reset, so a prescaled first count comes
// at any phase; other timers' bits in the shared registers read zero
// and are never stored here
// observation: the tick output is the tick delayed one clock, so it
// rises together with the count it caused
`timescale 1ns/1ps
module tc8_timer
(
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   // i/o register bus from the cpu core
   input  wire logic [6:0] i_bus_addr,
   input  wire logic       i_bus_io_space,
   input  wire logic       i_bus_wr,
   input  wire logic       i_bus_rd,
   input  wire logic [7:0] i_bus_wdata,
   output logic      [7:0] o_bus_rdata,
   output logic            o_bus_rvalid,
   // interrupt side
   input  wire logic       i_global_irq_en,
   input  wire logic       i_ovf_irq_ack,
   output logic            o_ovf_irq,
   // external count pin level as seen at the pad
   input  wire logic       i_external_count_pin,
   // observation
   output logic      [7:0] o_count_value,
   output logic            o_overflow_flag,
   output logic            o_timer_clock_enable
);

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------

   logic hit_count;
   logic hit_control;
   logic hit_flags;
   logic hit_mask;
   logic wr_count;
   logic wr_control;
   logic wr_flags;
   logic wr_mask;

   // an i/o access beyond the i/o window maps nothing
   // data-space aliases match exactly, so nothing above them is decoded
   function automatic logic reg_hit
   (
      input logic [6:0] addr,
      input logic       io_space,
      input logic [6:0] offset
   );
      logic [6:0] data_addr;
      data_addr = 7'(offset + tc8_pkg::DATA_SPACE_BIAS);
      if (io_space)
         reg_hit = (addr <= tc8_pkg::IO_SPACE_MAX) && (addr == offset);
      else
         reg_hit = (addr == data_addr);
   endfunction

   // each register answers at its i/o offset and its data-space alias
   // rd and wr are not gated by each other; raised together, both act
   always_comb
   begin
      hit_count   = reg_hit(i_bus_addr, i_bus_io_space, tc8_pkg::OFF_COUNT_VALUE);
      hit_control = reg_hit(i_bus_addr, i_bus_io_space, tc8_pkg::OFF_TIMER_CONTROL);
      hit_flags   = reg_hit(i_bus_addr, i_bus_io_space,
                            tc8_pkg::OFF_TIMER_INTERRUPT_FLAGS);
      hit_mask    = reg_hit(i_bus_addr, i_bus_io_space,
                            tc8_pkg::OFF_TIMER_INTERRUPT_MASK);
      wr_count    = i_bus_wr & hit_count;
      wr_control  = i_bus_wr & hit_control;
      wr_flags    = i_bus_wr & hit_flags;
      wr_mask     = i_bus_wr & hit_mask;
   end

   // ------------------------------------------------------------------
   // clock sources
   // ------------------------------------------------------------------

   logic [tc8_pkg::TAP_COUNT-1:0] tap_en;
   logic                          pin_rise;
   logic                          pin_fall;

   // shared prescaler keeps running whatever this timer selects
   // ten bits cover the largest divide, 1024
   tc8_prescaler u_prescaler
   (
      .i_clock  (i_clock),
      .i_rst_b  (i_rst_b),
      .o_tap_en (tap_en)
   );

   // pad level is used, so software driving the pin as an output still counts
   // two sampling flops and the count register set the pin-to-count delay
   tc8_edge_det u_edge_det
   (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_pin   (i_external_count_pin),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------

   logic [2:0] clock_select_field_q;
   logic [2:0] clock_select_field_d;

   // only the select field is kept; upper bits read as zero
   // reserved bits are dropped on write, so no storage is spent on them
   always_comb
   begin
      clock_select_field_d = clock_select_field_q;
      if (wr_control)
         clock_select_field_d = i_bus_wdata[tc8_pkg::CS_LSB +: tc8_pkg::CS_WIDTH];
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         clock_select_field_q <= tc8_pkg::RST_CLOCK_SELECT;
      else
         clock_select_field_q <= clock_select_field_d;
   end

   // ------------------------------------------------------------------
   // timer clock select
   // ------------------------------------------------------------------

   logic timer_clock_enable;

   // the tick is an enable on the system clock, never a clock of its own
   // changing to a pin mode while the pin moves may give one stray tick
   always_comb
   begin
      timer_clock_enable = 1'b0;
      unique case (clock_select_field_q)
         tc8_pkg::CS_STOP     : timer_clock_enable = 1'b0;
         tc8_pkg::CS_DIV1     : timer_clock_enable = 1'b1;
         tc8_pkg::CS_DIV8     : timer_clock_enable = tap_en[tc8_pkg::TAP_8];
         tc8_pkg::CS_DIV64    : timer_clock_enable = tap_en[tc8_pkg::TAP_64];
         tc8_pkg::CS_DIV256   : timer_clock_enable = tap_en[tc8_pkg::TAP_256];
         tc8_pkg::CS_DIV1024  : timer_clock_enable = tap_en[tc8_pkg::TAP_1024];
         tc8_pkg::CS_EXT_FALL : timer_clock_enable = pin_fall;
         tc8_pkg::CS_EXT_RISE : timer_clock_enable = pin_rise;
      endcase
   end

   // ------------------------------------------------------------------
   // counter unit
   // ------------------------------------------------------------------

   logic [7:0] count_value_q;
   logic [7:0] count_value_d;
   logic       ovf_event;

   // a cpu write wins over a tick; a wrap that loses to a write sets no flag
   // the wrap is judged on the old value, so the flag lands with the zero
   always_comb
   begin
      count_value_d = count_value_q;
      ovf_event     = 1'b0;
      if (wr_count)
      begin
         count_value_d = i_bus_wdata;
      end
      else if (timer_clock_enable)
      begin
         count_value_d = count_value_q + tc8_pkg::COUNT_ONE;
         ovf_event     = (count_value_q == tc8_pkg::COUNT_MAX);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         count_value_q <= tc8_pkg::RST_COUNT_VALUE;
      else
         count_value_q <= count_value_d;
   end

   // ------------------------------------------------------------------
   // overflow flag and interrupt mask (bit zero of the shared registers)
   // ------------------------------------------------------------------

   logic overflow_flag_q;
   logic overflow_flag_d;
   logic overflow_irq_enable_q;
   logic overflow_irq_enable_d;
   logic ovf_clear;

   // set wins over a clear in the same cycle so no overflow is ever lost
   always_comb
   begin
      ovf_clear = i_ovf_irq_ack
                | (wr_flags & i_bus_wdata[tc8_pkg::OVF_FLAG_BIT]);
      overflow_flag_d = overflow_flag_q;
      if (ovf_event)
         overflow_flag_d = 1'b1;
      else if (ovf_clear)
         overflow_flag_d = 1'b0;
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         overflow_flag_q <= tc8_pkg::RST_OVERFLOW_FLAG;
      else
         overflow_flag_q <= overflow_flag_d;
   end

   // only bit zero of the shared mask is kept; other timers own the rest
   always_comb
   begin
      overflow_irq_enable_d = overflow_irq_enable_q;
      if (wr_mask)
         overflow_irq_enable_d = i_bus_wdata[tc8_pkg::OVF_IE_BIT];
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         overflow_irq_enable_q <= tc8_pkg::RST_OVF_IRQ_EN;
      else
         overflow_irq_enable_q <= overflow_irq_enable_d;
   end

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------

   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       rvalid_q;
   logic       rvalid_d;

   // read data is registered; unmapped reads and other timers' bits give zero
   // a read taken with a write returns the value from before the write
   always_comb
   begin
      rdata_d  = rdata_q;
      rvalid_d = i_bus_rd;
      if (i_bus_rd)
      begin
         rdata_d = tc8_pkg::RST_READ_DATA;
         if (hit_count)
            rdata_d = count_value_q;
         else if (hit_control)
            rdata_d[tc8_pkg::CS_LSB +: tc8_pkg::CS_WIDTH] = clock_select_field_q;
         else if (hit_flags)
            rdata_d[tc8_pkg::OVF_FLAG_BIT] = overflow_flag_q;
         else if (hit_mask)
            rdata_d[tc8_pkg::OVF_IE_BIT] = overflow_irq_enable_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rdata_q  <= tc8_pkg::RST_READ_DATA;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ------------------------------------------------------------------
   // interrupt request and observation outputs
   // ------------------------------------------------------------------

   logic ovf_irq_q;
   logic ovf_irq_d;
   logic tick_seen_q;
   logic tick_seen_d;

   // registered request lags the flag by one clock; ack must see it drop
   always_comb
   begin
      ovf_irq_d = overflow_irq_enable_q & i_global_irq_en & overflow_flag_q;
   end

   // observation copy of the tick, one clock late, so the output is a flop
   always_comb
   begin
      tick_seen_d = timer_clock_enable;
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ovf_irq_q   <= 1'b0;
         tick_seen_q <= 1'b0;
      end
      else
      begin
         ovf_irq_q   <= ovf_irq_d;
         tick_seen_q <= tick_seen_d;
      end
   end

   // every output is a flop, so nothing combinational reaches a pin
   assign o_bus_rdata          = rdata_q;
   assign o_bus_rvalid         = rvalid_q;
   assign o_ovf_irq            = ovf_irq_q;
   assign o_count_value        = count_value_q;
   assign o_overflow_flag      = overflow_flag_q;
   assign o_timer_clock_enable = tick_seen_q;

endmodule

// >>> test/tc8_timer_assertions.sv
// port-level checker for the 8-bit timer/counter
`timescale 1ns/1ps
module tc8_timer_assertions
(
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic [6:0] i_bus_addr,
   input  wire logic       i_bus_io_space,
   input  wire logic       i_bus_wr,
   input  wire logic       i_bus_rd,
   input  wire logic [7:0] i_bus_wdata,
   input  wire logic       o_bus_rvalid,
   input  wire logic       i_global_irq_en,
   input  wire logic       i_ovf_irq_ack,
   input  wire logic       o_ovf_irq,
   input  wire logic [7:0] o_count_value,
   input  wire logic       o_overflow_flag,
   input  wire logic       o_timer_clock_enable
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   // any write is excluded below because a write beats the tick
   read_answer_a: assert property (i_bus_rd |=> o_bus_rvalid)
      else $error("read strobe gave no rvalid");
   count_load_a: assert property (i_bus_wr && i_bus_io_space && i_bus_addr == 7'h32
      |=> o_count_value == $past(i_bus_wdata))
      else $error("count write not loaded");
   count_step_a: assert property (o_timer_clock_enable && !$past(i_bus_wr)
      |-> o_count_value == $past(o_count_value) + 8'h01)
      else $error("tick did not add one");
   count_hold_a: assert property (!o_timer_clock_enable && !$past(i_bus_wr)
      |-> $stable(o_count_value))
      else $error("count moved without tick");
   wrap_flag_a: assert property (o_timer_clock_enable && o_count_value == 8'h00
      && !$past(i_bus_wr) |-> o_overflow_flag)
      else $error("wrap did not set flag");
   flag_clear_src_a: assert property ($fell(o_overflow_flag)
      |-> $past(i_ovf_irq_ack) || $past(i_bus_wr))
      else $error("flag cleared with no cause");
   ack_clear_a: assert property (i_ovf_irq_ack && o_count_value != 8'hff
      |=> !o_overflow_flag)
      else $error("service did not clear flag");
   irq_gate_a: assert property (o_ovf_irq
      |-> $past(i_global_irq_en) && $past(o_overflow_flag))
      else $error("irq without enable and flag");
endmodule

bind tc8_timer tc8_timer_assertions tc8_timer_assertions_inst
(
   .i_clock(i_clock), .i_rst_b(i_rst_b), .i_bus_addr(i_bus_addr),
   .i_bus_io_space(i_bus_io_space), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
   .i_bus_wdata(i_bus_wdata), .o_bus_rvalid(o_bus_rvalid),
   .i_global_irq_en(i_global_irq_en), .i_ovf_irq_ack(i_ovf_irq_ack),
   .o_ovf_irq(o_ovf_irq), .o_count_value(o_count_value),
   .o_overflow_flag(o_overflow_flag), .o_timer_clock_enable(o_timer_clock_enable)
);

// >>> test/tc8_cpu_model.sv
// cpu core model driving the i/o register bus
`timescale 1ns/1ps
module tc8_cpu_model
(
   input  wire logic       i_clock,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   output logic      [6:0] o_addr,
   output logic            o_io_space,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_wdata
);
   initial
   begin
      o_addr = 7'h00;
      o_io_space = 1'b1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end

   // data space adds the bias, i/o space uses the offset itself
   task automatic bus_write(input logic [6:0] off, input logic io, input logic [7:0] d);
      @(negedge i_clock);
      o_io_space = io;
      o_addr = io ? off : off + 7'h20;
      o_wdata = d; // a one clears the flag
      o_wr = 1'b1;
      @(negedge i_clock);
      o_wr = 1'b0;
      o_wdata = ~d; // released data shows garbage
   endtask

   // answer is taken one cycle after the strobe
   task automatic bus_read(input logic [6:0] off, input logic io, output logic [7:0] d,
                           output logic v);
      @(negedge i_clock);
      o_io_space = io;
      o_addr = io ? off : off + 7'h20;
      o_rd = 1'b1;
      @(negedge i_clock);
      o_rd = 1'b0;
      d = i_rdata;
      v = i_rvalid;
   endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ps
module testbench;
   logic       i_clock;
   logic       i_rst_b;
   logic [6:0] bus_addr;
   logic       bus_io, bus_wr, bus_rd, bus_rvalid, global_en, irq_ack, ext_pin;
   logic [7:0] bus_wdata, bus_rdata, count_value;
   logic       ovf_irq, ovf_flag, tick;
   int         fail_count, cmp_count;

   tc8_timer tc8_timer_inst
   (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_bus_addr(bus_addr),
      .i_bus_io_space(bus_io), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
      .i_bus_wdata(bus_wdata), .o_bus_rdata(bus_rdata), .o_bus_rvalid(bus_rvalid),
      .i_global_irq_en(global_en), .i_ovf_irq_ack(irq_ack), .o_ovf_irq(ovf_irq),
      .i_external_count_pin(ext_pin), .o_count_value(count_value),
      .o_overflow_flag(ovf_flag), .o_timer_clock_enable(tick)
   );

   tc8_cpu_model tc8_cpu_model_inst
   (
      .i_clock(i_clock), .i_rdata(bus_rdata), .i_rvalid(bus_rvalid), .o_addr(bus_addr),
      .o_io_space(bus_io), .o_wr(bus_wr), .o_rd(bus_rd), .o_wdata(bus_wdata)
   );

   // 20 MHz system clock
   initial
   begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [6:0] off, input logic io, input logic [7:0] d);
      tc8_cpu_model_inst.bus_write(off, io, d);
   endtask

   task automatic rd(input logic [6:0] off, input logic io, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      tc8_cpu_model_inst.bus_read(off, io, d, v);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask

   // bounded wait for a count value; n is the falling edges it took
   task automatic wait_cnt(input logic [7:0] v, input int lim, output int n);
      n = 0;
      while (count_value !== v)
      begin
         @(negedge i_clock);
         n++;
         if (n > lim)
         begin
            fail_count++;
            summarize();
         end
      end
   endtask

   // each level is held four clocks; the count moves on the third edge only
   task automatic pin_to(input logic lvl, input logic hit);
      logic [7:0] c0;
      c0 = count_value;
      @(negedge i_clock);
      ext_pin = lvl;
      repeat (2) @(negedge i_clock);
      check(count_value, c0);
      @(negedge i_clock);
      check(count_value, c0 + {7'h00, hit});
   endtask

   // every register in both spaces after reset, plus one unmapped place
   task automatic s_reset;
      logic [6:0] offs [4] = '{7'h32, 7'h33, 7'h38, 7'h39};
      foreach (offs[i])
      begin
         rd(offs[i], 1'b1, 8'h00);
         rd(offs[i], 1'b0, 8'h00);
      end
      rd(7'h40, 1'b1, 8'h00);
   endtask

   task automatic s_regs;
      wr(7'h33, 1'b1, 8'hf8);
      rd(7'h33, 1'b0, 8'h00);
      wr(7'h39, 1'b1, 8'hff);
      rd(7'h39, 1'b1, 8'h01);
      wr(7'h32, 1'b0, 8'ha5);
      repeat (20) @(negedge i_clock);
      rd(7'h32, 1'b1, 8'ha5);
   endtask

   task automatic s_wrap;
      int n;
      global_en = 1'b1;
      wr(7'h32, 1'b1, 8'hfd);
      wr(7'h33, 1'b1, 8'h01);
      wait_cnt(8'h00, 10, n);
      check({7'h00, ovf_flag}, 8'h01);
      @(negedge i_clock);
      check({7'h00, ovf_irq}, 8'h01);
      global_en = 1'b0;
      @(negedge i_clock);
      check({7'h00, ovf_irq}, 8'h00);
      global_en = 1'b1;
      wr(7'h39, 1'b1, 8'h00);
      @(negedge i_clock);
      check({7'h00, ovf_irq}, 8'h00);
      global_en = 1'b0;
      wr(7'h39, 1'b1, 8'h01);
      wr(7'h33, 1'b1, 8'h00);
      rd(7'h38, 1'b0, 8'h01);
      wr(7'h38, 1'b1, 8'h00);
      check({7'h00, ovf_flag}, 8'h01);
      wr(7'h38, 1'b1, 8'h01);
      check({7'h00, ovf_flag}, 8'h00);
      wr(7'h32, 1'b1, 8'hff);
      wr(7'h33, 1'b1, 8'h01);
      wait_cnt(8'h00, 10, n);
      check({7'h00, ovf_flag}, 8'h01);
      wr(7'h33, 1'b1, 8'h00);
      irq_ack = 1'b1;
      @(negedge i_clock);
      irq_ack = 1'b0;
      check({7'h00, ovf_flag}, 8'h00);
   endtask

   task automatic s_prio;
      wr(7'h33, 1'b1, 8'h01);
      wr(7'h32, 1'b1, 8'h10);
      check(count_value, 8'h10);
      @(negedge i_clock);
      check(count_value, 8'h11);
      check({7'h00, tick}, 8'h01);
      wr(7'h33, 1'b1, 8'h00);
   endtask

   task automatic s_presc;
      int div [4] = '{8, 64, 256, 1024};
      int n;
      foreach (div[i])
      begin
         wr(7'h33, 1'b1, 8'h00);
         wr(7'h32, 1'b1, 8'h00);
         wr(7'h33, 1'b1, 8'h02 + 8'(i));
         wait_cnt(8'h01, div[i] + 2, n);
         check({7'h00, n <= div[i] + 1}, 8'h01);
         wait_cnt(8'h02, div[i] + 2, n);
         check({7'h00, n == div[i]}, 8'h01);
      end
      wr(7'h33, 1'b1, 8'h00);
   endtask

   // the pin is driven from outside the block, as software driving an output would
   task automatic s_ext;
      wr(7'h32, 1'b1, 8'h00);
      wr(7'h33, 1'b1, 8'h06);
      pin_to(1'b1, 1'b0);
      pin_to(1'b0, 1'b1);
      pin_to(1'b1, 1'b0);
      pin_to(1'b0, 1'b1);
      wr(7'h33, 1'b1, 8'h07);
      pin_to(1'b1, 1'b1);
      pin_to(1'b0, 1'b0);
      check(count_value, 8'h03);
   endtask

   // reset, then scenarios in turn
   initial
   begin
      fail_count = 0;
      cmp_count = 0;
      ext_pin = 1'b0;
      global_en = 1'b0;
      irq_ack = 1'b0;
      i_rst_b = 1'b0;
      repeat (6) @(negedge i_clock);
      i_rst_b = 1'b1;
      s_reset();
      s_regs();
      s_wrap();
      s_prio();
      s_presc();
      s_ext();
      summarize();
   end
endmodule
